// >>> rtl/mcs_selector.sv
/*
  Multi-setup selector top: APB registers, setup memory, switch control.
  Assumes synchronous drive inputs and an APB master on pclk.
*/
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module mcs_selector (
  // APB
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Drive side
  input  wire logic [mcs_pkg::NDIN-1:0]   din,
  input  wire logic [15:0]                cmd_word,
  input  wire logic                       drive_stopped,
  input  wire logic [7:0]                 hw_installed,
  input  wire logic                       dc_bus_on,
  input  wire logic [mcs_pkg::NSETUP-1:0] motor_heating,
  // Results
  output logic [1:0]                      active_setup,
  output logic                            drive_locked,
  output logic                            empty_slot_lock,
  output logic                            hw_mismatch_lock,
  output logic                            autotune_req,
  output logic [mcs_pkg::NSETUP-1:0]      setup_ind_out,
  output logic [mcs_pkg::NRELAY-1:0]      relay_out,
  output logic [mcs_pkg::NDOUT-1:0]       dout_out,
  output logic                            irq
);
  logic [31:0] work_ff [mcs_pkg::NGROUP];
  logic [31:0] slot_ff [mcs_pkg::NSETUP][mcs_pkg::NGROUP];
  logic [7:0]  slot_hw_ff [mcs_pkg::NSETUP];
  logic [15:0] thermal_ff [mcs_pkg::NSETUP];
  logic [31:0] autotune_ff [mcs_pkg::NSETUP];
  logic [mcs_pkg::NSETUP-1:0] slot_valid_ff;
  logic [mcs_pkg::NSETUP-1:0] ind_en_ff;
  logic [31:0] comm_ff;
  logic        multi_motor_select_ff;
  logic        power_up_autotune_ff;
  logic        io_profile_ff;
  logic [4:0]  setup_select_bit0_ff;
  logic [4:0]  setup_select_bit1_ff;
  logic [3:0]  precharge_output_assign_ff;
  logic [9:0]  precharge_charge_time_ff;
  logic [1:0]  active_ff;
  logic        pending_ff;
  logic        empty_ff;
  logic        hwmm_ff;
  logic        at_done_ff;
  logic [mcs_pkg::IRQ_W-1:0] irq_st_ff;
  logic [mcs_pkg::IRQ_W-1:0] irq_en_ff;
  logic [31:0] prdata_ff;
  logic        charge_done;
  logic        charge_done_d_ff;
  logic        sel_b0;
  logic        sel_b1;
  logic [1:0]  sel_idx;
  logic        do_switch;
  logic        wr;
  logic        rd;
  logic        store;
  logic [mcs_pkg::IRQ_W-1:0] irq_set;
  logic [31:0] rd_mux;
  logic        rd_err;
  logic [1:0]  tune_idx;

  // Resolve one select source to a level
  function automatic logic src_level(input logic [4:0] src, input logic [15:0] di,
                                     input logic [15:0] cw, input logic iop);
    logic r;
    r = 1'b0;
    if (src == mcs_pkg::SRC_NONE) begin
      r = 1'b0;
    end else if (src <= mcs_pkg::SRC_DI_HI) begin
      r = di[4'(src - mcs_pkg::SRC_DI_LO)];
    end else if (src <= mcs_pkg::SRC_CMD_IO) begin
      r = iop & cw[4'(src - mcs_pkg::SRC_CMD0)];
    end else begin
      r = cw[4'(src - mcs_pkg::SRC_CMD0)];
    end
    return r;
  endfunction

  // Group index within the slot window
  function automatic logic [2:0] grp_of(input logic [11:0] a);
    logic [11:0] off;
    off = a - mcs_pkg::REG_SLOT;
    return off[6:4];
  endfunction

  assign sel_b0  = src_level(setup_select_bit0_ff, din, cmd_word, io_profile_ff);
  assign sel_b1  = src_level(setup_select_bit1_ff, din, cmd_word, io_profile_ff);
  assign sel_idx = {sel_b1, sel_b0};
  assign tune_idx = multi_motor_select_ff ? active_ff : 2'h0;
  assign do_switch = drive_stopped && (sel_idx != active_ff);
  assign wr    = psel && penable && pwrite;
  assign rd    = psel && !penable && !pwrite;
  assign store = wr && paddr == mcs_pkg::REG_CTRL && pwdata[mcs_pkg::CTRL_STORE];

  // APB configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multi_motor_select_ff      <= 1'b0;
      power_up_autotune_ff       <= 1'b0;
      io_profile_ff              <= 1'b0;
      setup_select_bit0_ff       <= mcs_pkg::SRC_NONE;
      setup_select_bit1_ff       <= mcs_pkg::SRC_NONE;
      precharge_output_assign_ff <= mcs_pkg::PCO_NONE;
      precharge_charge_time_ff   <= 10'h000;
      ind_en_ff                  <= '0;
      comm_ff                    <= 32'h0000_0000;
      irq_en_ff                  <= '0;
    end else if (wr) begin
      case (paddr)
        mcs_pkg::REG_CTRL: begin
          multi_motor_select_ff <= pwdata[mcs_pkg::CTRL_MM];
          power_up_autotune_ff  <= pwdata[mcs_pkg::CTRL_AUTO];
          io_profile_ff         <= pwdata[mcs_pkg::CTRL_IOPRF];
        end
        mcs_pkg::REG_SRC: begin
          setup_select_bit0_ff <= pwdata[4:0];
          setup_select_bit1_ff <= pwdata[12:8];
        end
        mcs_pkg::REG_PRECH: begin
          precharge_output_assign_ff <= pwdata[3:0];
          if (pwdata[3:0] != mcs_pkg::PCO_NONE && pwdata[25:16] <= mcs_pkg::CHG_MAX) begin
            precharge_charge_time_ff <= pwdata[25:16];
          end
        end
        mcs_pkg::REG_COMM: comm_ff <= pwdata;
        mcs_pkg::REG_IND:  ind_en_ff <= pwdata[3:0];
        mcs_pkg::REG_IRQ_EN: irq_en_ff <= pwdata[mcs_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Working set: written by software, reloaded on switch from a valid slot with matching hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int g = 0; g < mcs_pkg::NGROUP; g++) begin
        work_ff[g] <= 32'h0000_0000;
      end
    end else if (do_switch && slot_valid_ff[sel_idx] && slot_hw_ff[sel_idx] == hw_installed) begin
      for (int g = 0; g < mcs_pkg::NGROUP; g++) begin
        // Motor group stays shared in single-motor mode
        if (g != 0 || multi_motor_select_ff) begin
          work_ff[g] <= slot_ff[sel_idx][g];
        end
      end
    end else if (wr && paddr >= mcs_pkg::REG_WORK && paddr < mcs_pkg::REG_COMM) begin
      work_ff[0] <= (paddr == mcs_pkg::REG_WORK) ? pwdata : work_ff[0];
    end else if (wr && paddr >= mcs_pkg::REG_SLOT && paddr < mcs_pkg::REG_SLOT + 12'h050 && paddr[3:2] == 2'h0) begin
      work_ff[grp_of(paddr)] <= pwdata;
    end
  end

  // Slot store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_valid_ff <= '0;
      for (int s = 0; s < mcs_pkg::NSETUP; s++) begin
        slot_hw_ff[s] <= 8'h00;
        for (int g = 0; g < mcs_pkg::NGROUP; g++) begin
          slot_ff[s][g] <= 32'h0000_0000;
        end
      end
    end else if (store) begin
      slot_valid_ff[sel_idx] <= 1'b1;
      slot_hw_ff[sel_idx]    <= hw_installed;
      for (int g = 0; g < mcs_pkg::NGROUP; g++) begin
        slot_ff[sel_idx][g] <= work_ff[g];
      end
    end
  end

  // Active setup, locks and pending flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff  <= 2'h0;
      pending_ff <= 1'b0;
      empty_ff   <= 1'b0;
      hwmm_ff    <= 1'b0;
    end else begin
      pending_ff <= !drive_stopped && (sel_idx != active_ff);
      if (do_switch) begin
        active_ff <= sel_idx;
        empty_ff  <= !slot_valid_ff[sel_idx];
        hwmm_ff   <= slot_valid_ff[sel_idx] && slot_hw_ff[sel_idx] != hw_installed;
      end else if (wr && paddr == mcs_pkg::REG_CTRL && pwdata[mcs_pkg::CTRL_UNLK]) begin
        empty_ff <= 1'b0;
        hwmm_ff  <= 1'b0;
      end
    end
  end

  // Autotune store and power-up request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      at_done_ff <= 1'b0;
      for (int m = 0; m < mcs_pkg::NSETUP; m++) begin
        autotune_ff[m] <= 32'h0000_0000;
      end
    end else begin
      if (power_up_autotune_ff && multi_motor_select_ff && drive_stopped) begin
        at_done_ff <= 1'b1;
      end
      if (wr && paddr == mcs_pkg::REG_TUNE) begin
        autotune_ff[tune_idx] <= pwdata;
      end
    end
  end

  // Per-motor thermal state, volatile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < mcs_pkg::NSETUP; m++) begin
        thermal_ff[m] <= 16'h0000;
      end
    end else begin
      for (int m = 0; m < mcs_pkg::NSETUP; m++) begin
        // Heating while driven, cooling at all other times including stops
        if (motor_heating[m] && thermal_ff[m] != 16'hFFFF) begin
          thermal_ff[m] <= thermal_ff[m] + 16'h0001;
        end else if (!motor_heating[m] && thermal_ff[m] != 16'h0000) begin
          thermal_ff[m] <= thermal_ff[m] - 16'h0001;
        end
      end
    end
  end

  mcs_precharge u_pre (
    .pclk        (pclk),
    .presetn     (presetn),
    .bus_on      (dc_bus_on),
    .assign_sel  (precharge_output_assign_ff),
    .charge_time (precharge_charge_time_ff),
    .relay_out   (relay_out),
    .dout_out    (dout_out),
    .charge_done (charge_done)
  );

  // Interrupt status, set wins over clear
  assign irq_set = {charge_done && !charge_done_d_ff, do_switch,
                    do_switch && slot_valid_ff[sel_idx] && slot_hw_ff[sel_idx] != hw_installed,
                    do_switch && !slot_valid_ff[sel_idx]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_ff        <= '0;
      charge_done_d_ff <= 1'b0;
    end else begin
      charge_done_d_ff <= charge_done;
      irq_st_ff <= (irq_st_ff & ~((wr && paddr == mcs_pkg::REG_IRQ_CL) ?
                   pwdata[mcs_pkg::IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      mcs_pkg::REG_CTRL:   rd_mux = {27'h0, io_profile_ff, 2'h0, power_up_autotune_ff, multi_motor_select_ff};
      mcs_pkg::REG_SRC:    rd_mux = {19'h0, setup_select_bit1_ff, 3'h0, setup_select_bit0_ff};
      mcs_pkg::REG_STATUS: rd_mux = {24'h0, slot_valid_ff, hwmm_ff, empty_ff, pending_ff, 1'b0} | {30'h0, active_ff} << 8;
      mcs_pkg::REG_IRQ_ST: rd_mux = {28'h0, irq_st_ff};
      mcs_pkg::REG_IRQ_EN: rd_mux = {28'h0, irq_en_ff};
      mcs_pkg::REG_PRECH:  rd_mux = {6'h0, precharge_charge_time_ff, 11'h0, charge_done, precharge_output_assign_ff};
      mcs_pkg::REG_HW:     rd_mux = {24'h0, hw_installed};
      mcs_pkg::REG_WORK:   rd_mux = work_ff[0];
      mcs_pkg::REG_COMM:   rd_mux = comm_ff;
      mcs_pkg::REG_IND:    rd_mux = {28'h0, ind_en_ff};
      mcs_pkg::REG_TUNE:   rd_mux = autotune_ff[tune_idx];
      mcs_pkg::REG_THERM:  rd_mux = {16'h0, thermal_ff[active_ff]};
      mcs_pkg::REG_IRQ_CL: rd_mux = 32'h0000_0000;
      default: begin
        if (paddr >= mcs_pkg::REG_SLOT && paddr < mcs_pkg::REG_SLOT + 12'h050) begin
          rd_mux = work_ff[grp_of(paddr)];
        end else begin
          rd_mux = mcs_pkg::SLVERR_RD;
          rd_err = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd) begin
      prdata_ff <= rd_mux;
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && rd_err;
  assign active_setup     = active_ff;
  assign empty_slot_lock  = empty_ff;
  assign hw_mismatch_lock = hwmm_ff;
  assign drive_locked     = empty_ff | hwmm_ff;
  assign autotune_req     = power_up_autotune_ff && multi_motor_select_ff && !at_done_ff;
  assign irq              = |(irq_st_ff & irq_en_ff);
  always_comb begin
    for (int i = 0; i < mcs_pkg::NSETUP; i++) begin
      setup_ind_out[i] = ind_en_ff[i] && (active_ff == 2'(i));
    end
  end
endmodule // mcs_selector
`default_nettype wire

// >>> rtl/mcs_pkg.sv
/*
  Package for the multi-setup selector: register map, field codes, timing.
  Assumes a 100 MHz APB clock and a single drive controller around it.
*/
package mcs_pkg;
  localparam int          NSETUP     = 4;
  localparam int          NGROUP     = 5;
  localparam int          NDIN       = 16;
  localparam int          NRELAY     = 8;
  localparam int          NDOUT      = 4;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_SRC    = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_IRQ_ST = 12'h00C;
  localparam logic [11:0] REG_IRQ_EN = 12'h010;
  localparam logic [11:0] REG_IRQ_CL = 12'h014;
  localparam logic [11:0] REG_PRECH  = 12'h018;
  localparam logic [11:0] REG_HW     = 12'h01C;
  localparam logic [11:0] REG_WORK   = 12'h020;
  localparam logic [11:0] REG_COMM   = 12'h024;
  localparam logic [11:0] REG_IND    = 12'h028;
  localparam logic [11:0] REG_TUNE   = 12'h02C;
  localparam logic [11:0] REG_THERM  = 12'h030;
  localparam logic [11:0] REG_SLOT   = 12'h040;
  // Control fields
  localparam int          CTRL_MM    = 0;
  localparam int          CTRL_AUTO  = 1;
  localparam int          CTRL_STORE = 2;
  localparam int          CTRL_UNLK  = 3;
  localparam int          CTRL_IOPRF = 4;
  // Source code: 0 none, 1..16 digital input, 17..31 command bit 1..15
  localparam logic [4:0]  SRC_NONE   = 5'h00;
  localparam logic [4:0]  SRC_DI_LO  = 5'h01;
  localparam logic [4:0]  SRC_DI_HI  = 5'h10;
  localparam logic [4:0]  SRC_CMD0   = 5'h10;
  localparam logic [4:0]  SRC_CMD_IO = 5'h1A;
  // Precharge output code: 0 none, 1..8 relay, 9..12 digital output
  localparam logic [3:0]  PCO_NONE   = 4'h0;
  localparam logic [3:0]  PCO_RL_HI  = 4'h8;
  localparam logic [3:0]  PCO_DO_HI  = 4'hC;
  // Charge time in units of 10 ms
  localparam int          TICK_MS    = 10;
  localparam int          CLK_MHZ    = 100;
  localparam int          TICK_CYC   = TICK_MS * 1000 * CLK_MHZ;
  localparam logic [9:0]  CHG_MAX    = 10'h3E8;
  // Interrupt bits
  localparam int          IRQ_EMPTY  = 0;
  localparam int          IRQ_HWMM   = 1;
  localparam int          IRQ_SWITCH = 2;
  localparam int          IRQ_CHGDN  = 3;
  localparam int          IRQ_W      = 4;
  localparam logic [31:0] SLVERR_RD  = 32'h0000_0000;
  typedef enum logic [2:0] {
    MCS_IDLE  = 3'b001,
    MCS_CHG   = 3'b010,
    MCS_READY = 3'b100
  } mcs_pre_t;
endpackage

// >>> rtl/mcs_precharge.sv
/*
  Precharge contactor sequencer and output router.
  Assumes enable comes from the drive's supply logic and mcs_pkg timing.
*/
`timescale 1ns/100ps
`default_nettype none
module mcs_precharge #(
  parameter int TICK_CYC = mcs_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Control
  input  wire logic                     bus_on,
  input  wire logic [3:0]               assign_sel,
  input  wire logic [9:0]               charge_time,
  // Outputs
  output logic [mcs_pkg::NRELAY-1:0]    relay_out,
  output logic [mcs_pkg::NDOUT-1:0]     dout_out,
  output logic                          charge_done
);
  mcs_pkg::mcs_pre_t state_ff;
  logic [31:0]       tick_ff;
  logic [9:0]        cnt_ff;
  logic              contact;

  // Charge sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= mcs_pkg::MCS_IDLE;
      tick_ff  <= 32'h0000_0000;
      cnt_ff   <= 10'h000;
    end else begin
      case (state_ff)
        mcs_pkg::MCS_IDLE: begin
          tick_ff <= 32'h0000_0000;
          cnt_ff  <= 10'h000;
          if (bus_on && assign_sel != mcs_pkg::PCO_NONE) begin
            state_ff <= mcs_pkg::MCS_CHG;
          end
        end
        mcs_pkg::MCS_CHG: begin
          if (!bus_on) begin
            state_ff <= mcs_pkg::MCS_IDLE;
          end else if (cnt_ff >= charge_time) begin
            state_ff <= mcs_pkg::MCS_READY;
          end else if (tick_ff == 32'(TICK_CYC - 1)) begin
            tick_ff <= 32'h0000_0000;
            cnt_ff  <= cnt_ff + 10'h001;
          end else begin
            tick_ff <= tick_ff + 32'h0000_0001;
          end
        end
        mcs_pkg::MCS_READY: begin
          if (!bus_on || assign_sel == mcs_pkg::PCO_NONE) begin
            state_ff <= mcs_pkg::MCS_IDLE;
          end
        end
        default: state_ff <= mcs_pkg::MCS_IDLE;
      endcase
    end
  end

  assign contact     = (state_ff == mcs_pkg::MCS_READY);
  assign charge_done = contact;

  // Output routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_out <= '0;
      dout_out  <= '0;
    end else begin
      relay_out <= '0;
      dout_out  <= '0;
      if (contact && assign_sel != mcs_pkg::PCO_NONE) begin
        if (assign_sel <= mcs_pkg::PCO_RL_HI) begin
          relay_out[3'(assign_sel - 4'h1)] <= 1'b1;
        end else if (assign_sel <= mcs_pkg::PCO_DO_HI) begin
          dout_out[2'(assign_sel - 4'h9)] <= 1'b1;
        end
      end
    end
  end
endmodule // mcs_precharge
`default_nettype wire

// >>> testbench/mcs_selector_properties.sv
/* Checker for the multi-setup selector top ports.
   Assumes pclk with async active-low presetn; bound to every mcs_selector. */
`timescale 1ns/100ps
`default_nettype none
module mcs_selector_checker (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // APB
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Drive side
  input wire logic                       drive_stopped,
  input wire logic [1:0]                 active_setup,
  input wire logic                       drive_locked,
  input wire logic                       empty_slot_lock,
  input wire logic                       hw_mismatch_lock,
  input wire logic [mcs_pkg::NSETUP-1:0] setup_ind_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_write;
    psel && penable && pwrite;
  endsequence
  a_ready_access: assert property (s_access |-> pready)
    else $error("pready low in access");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_hold_running: assert property (!$past(drive_stopped) |-> $stable(active_setup))
    else $error("setup changed while running");
  a_ind_active: assert property ((setup_ind_out & ~(4'h1 << active_setup)) == 4'h0)
    else $error("indication for inactive setup");
  a_lock_cause: assert property ((empty_slot_lock || hw_mismatch_lock) |-> drive_locked)
    else $error("error without drive lock");
  a_empty_stopped: assert property ($rose(empty_slot_lock) |-> $past(drive_stopped))
    else $error("empty lock while running");
  a_hwmm_stopped: assert property ($rose(hw_mismatch_lock) |-> $past(drive_stopped))
    else $error("mismatch lock while running");
  a_unlock_write: assert property ($fell(drive_locked) |-> $past(psel && penable && pwrite))
    else $error("lock released without write");
  c_write: cover property (s_write);
endmodule // mcs_selector_checker
bind mcs_selector mcs_selector_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .drive_stopped(drive_stopped),
  .active_setup(active_setup), .drive_locked(drive_locked), .empty_slot_lock(empty_slot_lock),
  .hw_mismatch_lock(hw_mismatch_lock), .setup_ind_out(setup_ind_out));
`default_nettype wire

// >>> testbench/mcs_src_model.sv
/* Drive-side source model: digital inputs and command word.
   Assumes the bench sets the wanted select bits and the source kind. */
`timescale 1ns/100ps
`default_nettype none
module mcs_src_model (
  // Clock
  input  wire logic        pclk,
  // Request
  input  wire logic [1:0]  sel,
  input  wire logic        use_cmd,
  // Drive inputs
  output logic      [15:0] din,
  output logic      [15:0] cmd_word
);
  logic [13:0] noise_ff = 14'h0000;
  // Unused lines keep toggling
  always_ff @(posedge pclk) begin
    noise_ff <= noise_ff + 14'h0001;
  end
  assign din      = {noise_ff, use_cmd ? 2'h0 : sel};
  assign cmd_word = {noise_ff[12:10], use_cmd ? sel : 2'h0, use_cmd & sel[0], noise_ff[9:0]};
endmodule // mcs_src_model
`default_nettype wire

// >>> testbench/tb.sv
/* Self-checking bench for the multi-setup selector.
   Assumes the package register map and one 100 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %0t %s", $time, m); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic        drive_stopped, dc_bus_on, use_cmd, drive_locked, empty_slot_lock, hw_mismatch_lock, autotune_req, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [15:0] din, cmd_word;
  logic [7:0]  hw_installed, relay_out;
  logic [3:0]  motor_heating, setup_ind_out, dout_out;
  logic [1:0]  sel, active_setup;
  int          bad_count, num_checks;
  mcs_selector i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
    .cmd_word(cmd_word), .drive_stopped(drive_stopped), .hw_installed(hw_installed), .dc_bus_on(dc_bus_on),
    .motor_heating(motor_heating), .active_setup(active_setup), .drive_locked(drive_locked),
    .empty_slot_lock(empty_slot_lock), .hw_mismatch_lock(hw_mismatch_lock), .autotune_req(autotune_req),
    .setup_ind_out(setup_ind_out), .relay_out(relay_out), .dout_out(dout_out), .irq(irq));
  mcs_src_model i_src (.pclk(pclk), .sel(sel), .use_cmd(use_cmd), .din(din), .cmd_word(cmd_word));
  always #5 pclk = ~pclk;
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      tally_and_finish();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pick(input logic [1:0] k);
    int n;
    @(posedge pclk);
    sel <= k;
    for (n = 0; n < 8; n++) begin
      @(negedge pclk);
      if (active_setup === k) break;
    end
    `CHK(active_setup, k, "active setup")
    if (n == 8) tally_and_finish();
    @(negedge pclk);
  endtask
  task automatic t_reset();
    `CHK({active_setup, drive_locked, irq, setup_ind_out}, 8'h00, "reset outputs")
    rd(mcs_pkg::REG_CTRL);
    `CHK(rd_data, 32'h0000_0000, "ctrl reset")
    rd(mcs_pkg::REG_SRC);
    `CHK(rd_data, 32'h0000_0000, "source reset")
    rd(mcs_pkg::REG_PRECH);
    `CHK(rd_data, 32'h0000_0000, "precharge reset")
    rd(12'hFFC);
    `CHK(rd_err, 1'b1, "unmapped error")
  endtask
  task automatic t_empty();
    wr(mcs_pkg::REG_SRC, 32'h0000_0201);
    wr(mcs_pkg::REG_IRQ_EN, 32'h0000_0001);
    pick(2'h1);
    `CHK({empty_slot_lock, drive_locked, irq}, 3'h7, "empty lock")
    wr(mcs_pkg::REG_IRQ_EN, 32'h0000_0000);
    @(negedge pclk);
    `CHK(irq, 1'b0, "irq masked")
    wr(mcs_pkg::REG_IRQ_CL, 32'h0000_0001);
    wr(mcs_pkg::REG_IRQ_EN, 32'h0000_0001);
    @(negedge pclk);
    `CHK(irq, 1'b0, "irq cleared")
    wr(mcs_pkg::REG_CTRL, 32'h0000_0008);
    @(negedge pclk);
    `CHK({empty_slot_lock, drive_locked}, 2'h0, "unlock")
  endtask
  task automatic t_store();
    wr(mcs_pkg::REG_IND, 32'h0000_000F);
    wr(mcs_pkg::REG_COMM, 32'h0000_005A);
    for (int k = 0; k < 4; k++) begin
      pick(2'(k));
      wr(mcs_pkg::REG_CTRL, 32'h0000_0008);
      wr(mcs_pkg::REG_WORK, 32'h0000_0030 + 32'(k));
      wr(mcs_pkg::REG_SLOT + 12'h010, 32'h0000_00A0 + 32'(k));
      wr(mcs_pkg::REG_CTRL, 32'h0000_0004);
      @(negedge pclk);
      `CHK(setup_ind_out, 4'h1 << k, "indication")
    end
    rd(mcs_pkg::REG_STATUS);
    `CHK(rd_data[7:4], 4'hF, "slots stored")
  endtask
  task automatic t_swap();
    for (int j = 0; j < 4; j++) begin
      pick(2'((j + 2) % 4));
      rd(mcs_pkg::REG_SLOT + 12'h010);
      `CHK(rd_data[7:0], 8'hA0 + 8'((j + 2) % 4), "group swapped")
      rd(mcs_pkg::REG_COMM);
      `CHK(rd_data[7:0], 8'h5A, "comm kept")
      rd(mcs_pkg::REG_WORK);
      `CHK(rd_data[7:0], 8'h33, "motor shared")
    end
    wr(mcs_pkg::REG_CTRL, 32'h0000_0001);
    wr(mcs_pkg::REG_TUNE, 32'h0000_0071);
    pick(2'h2);
    rd(mcs_pkg::REG_WORK);
    `CHK(rd_data[7:0], 8'h32, "motor per setup")
    rd(mcs_pkg::REG_TUNE);
    `CHK(rd_data, 32'h0000_0000, "tune per motor")
    wr(mcs_pkg::REG_CTRL, 32'h0000_0000);
    pick(2'h0);
  endtask
  task automatic t_defer();
    @(posedge pclk);
    drive_stopped <= 1'b0;
    sel <= 2'h2;
    repeat (6) @(negedge pclk);
    `CHK(active_setup, 2'h0, "held while running")
    rd(mcs_pkg::REG_STATUS);
    `CHK(rd_data[1], 1'b1, "pending")
    wr(mcs_pkg::REG_CTRL, 32'h0000_0003);
    @(negedge pclk);
    `CHK(autotune_req, 1'b1, "autotune asked")
    @(posedge pclk);
    drive_stopped <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    `CHK(active_setup, 2'h2, "applied at stop")
    @(posedge pclk);
    drive_stopped <= 1'b0;
    sel <= 2'h1;
    repeat (4) @(posedge pclk);
    sel <= 2'h2;
    repeat (4) @(posedge pclk);
    drive_stopped <= 1'b1;
    repeat (4) @(negedge pclk);
    `CHK(active_setup, 2'h2, "request withdrawn")
    rd(mcs_pkg::REG_STATUS);
    `CHK(rd_data[1], 1'b0, "no pending")
    `CHK(autotune_req, 1'b0, "autotune taken")
  endtask
  task automatic t_hw_cmd();
    @(posedge pclk);
    hw_installed <= 8'h22;
    pick(2'h3);
    `CHK({hw_mismatch_lock, drive_locked}, 2'h3, "mismatch lock")
    @(posedge pclk);
    hw_installed <= 8'h11;
    wr(mcs_pkg::REG_CTRL, 32'h0000_0008);
    @(posedge pclk);
    use_cmd <= 1'b1;
    wr(mcs_pkg::REG_SRC, 32'h0000_1C1B);
    pick(2'h1);
    pick(2'h2);
    `CHK({active_setup, drive_locked}, 3'h4, "command bits")
    wr(mcs_pkg::REG_SRC, 32'h0000_1C1A);
    @(posedge pclk);
    sel <= 2'h3;
    repeat (3) @(negedge pclk);
    `CHK(active_setup, 2'h2, "low bit needs profile")
    wr(mcs_pkg::REG_CTRL, 32'h0000_0010);
    pick(2'h3);
    `CHK(active_setup, 2'h3, "low bit with profile")
  endtask
  task automatic t_prech();
    wr(mcs_pkg::REG_PRECH, 32'h0005_0000);
    rd(mcs_pkg::REG_PRECH);
    `CHK(rd_data[25:16], 10'h000, "time needs output")
    wr(mcs_pkg::REG_PRECH, 32'h03E8_0001);
    rd(mcs_pkg::REG_PRECH);
    `CHK(rd_data[25:16], 10'h3E8, "time max")
    wr(mcs_pkg::REG_PRECH, 32'h03E9_0001);
    rd(mcs_pkg::REG_PRECH);
    `CHK(rd_data[25:16], 10'h3E8, "time over max")
    `CHK(rd_data[3:0], 4'h1, "relay assigned")
    wr(mcs_pkg::REG_PRECH, 32'h0000_0001);
    @(posedge pclk);
    dc_bus_on <= 1'b1;
    repeat (4) @(negedge pclk);
    `CHK(relay_out, 8'h01, "contactor relay")
    rd(mcs_pkg::REG_PRECH);
    `CHK(rd_data[4], 1'b1, "charge done")
    wr(mcs_pkg::REG_PRECH, 32'h0000_0009);
    repeat (2) @(negedge pclk);
    `CHK({relay_out, dout_out}, 12'h001, "contactor dout")
    @(posedge pclk);
    dc_bus_on <= 1'b0;
    motor_heating <= 4'h8;
    repeat (3) @(negedge pclk);
    `CHK({relay_out, dout_out}, 12'h000, "contactor off")
    repeat (7) @(posedge pclk);
    motor_heating <= 4'h0;
    rd(mcs_pkg::REG_THERM);
    `CHK(rd_data, 32'h0000_0008, "thermal count")
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, dc_bus_on, use_cmd} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    drive_stopped = 1'b1;
    hw_installed = 8'h11;
    motor_heating = 4'h0;
    sel = 2'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_empty();
    t_store();
    t_swap();
    t_defer();
    t_hw_cmd();
    t_prech();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
